// ===== updc_cfg.svh
// constants for the upconverter data port control block
`ifndef UPDC_CFG_SVH
`define UPDC_CFG_SVH
`define UPDC_A_CTRL     32'h0000_0000
`define UPDC_A_STAT     32'h0000_0004
`define UPDC_A_IRQ      32'h0000_0008
`define UPDC_A_MASK     32'h0000_000C
`define UPDC_A_TW0      32'h0000_0010
`define UPDC_A_TW1      32'h0000_0014
`define UPDC_A_TW2      32'h0000_0018
`define UPDC_A_TW3      32'h0000_001C
`define UPDC_A_ACC      32'h0000_0020
`define UPDC_A_IQ       32'h0000_0024
`define UPDC_CTRL_RST   12'h000
`define UPDC_DIV_W      8
`define UPDC_DIV_RST    8'h04
`define UPDC_DIV_ONE    8'h01
`define UPDC_WORD_W     14
`define UPDC_TW_W       32
`define UPDC_EV_OVF     0
`define UPDC_EV_LOCK    1
`define UPDC_EV_UPD     2
`define UPDC_EV_PROF    3
`define UPDC_EV_W       4
`define UPDC_EV_ZERO    4'h0
`endif

// ===== updc_pkg.sv
// types for the upconverter data port control block
package updc_pkg;
  typedef enum logic [1:0] {
    UPDC_QUAD   = 2'b00,
    UPDC_SINGLE = 2'b01,
    UPDC_INTERP = 2'b10,
    UPDC_RSV    = 2'b11
  } updc_mode_t;
  typedef struct packed {
    logic [7:0] div;
    logic       keep_pll;
    logic       soft_pd;
    updc_mode_t mode;
  } updc_ctrl_t;
  typedef struct packed {
    logic [13:0] i_word;
    logic [13:0] q_word;
  } updc_iq_t;
endpackage

// ===== updc_top.sv
// data port, update strobe and control pins with an AHB-Lite register file
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "updc_cfg.svh"
module updc_top (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic [13:0] parallel_word_bus_in,
  input  wire logic        transmit_gate_in,
  input  wire logic        word_pin_in,
  output logic             word_pin_out,
  output logic             word_pin_oe_n_out,
  input  wire logic        profile_select_high_in,
  input  wire logic        profile_select_low_in,
  input  wire logic        digital_powerdown_input_in,
  input  wire logic        hw_reset_in,
  input  wire logic        differential_clock_select_in,
  input  wire logic        pll_locked_in,
  input  wire logic        interp_overflow_in,
  output logic             pll_lock_out,
  output logic             interpolator_overflow_flag_out,
  output logic             differential_ref_out,
  output logic             pll_run_out,
  output logic             digital_run_out,
  output updc_pkg::updc_iq_t iq_out,
  output logic             iq_valid_out,
  output logic [31:0]      accum_tw_out,
  output logic             irq_out
);
  // register and datapath state
  updc_pkg::updc_ctrl_t ctrl, next_ctrl;
  logic [31:0] tw [0:3];
  logic [31:0] next_tw [0:3];
  logic [31:0] acc_tw, next_acc_tw;
  logic [3:0]  irq_st, next_irq_st, irq_mask, next_irq_mask;
  updc_pkg::updc_iq_t iq, next_iq;
  logic        iq_vld, next_iq_vld;
  logic [13:0] i_hold, next_i_hold;
  logic        want_q, next_want_q;
  logic [7:0]  div_cnt, next_div_cnt;
  logic        wclk, next_wclk;
  logic        upd_d, next_upd_d;
  logic [1:0]  prof_d, next_prof_d;
  logic        lock_d, next_lock_d;
  logic        lock_arm, next_lock_arm;
  logic        ovf_q, next_ovf_q;
  logic        wr_pend, next_wr_pend;
  logic        rd_pend, next_rd_pend;
  logic [31:0] dp_addr, next_dp_addr;
  logic [31:0] rdata, next_rdata;

  // local reset and derived conditions
  logic        clr;
  logic        pd;
  logic        single;
  logic [1:0]  prof;
  logic        wtick;
  logic        word_take;
  logic        upd_rise;
  logic        prof_chg;
  logic [3:0]  ev;
  logic        rd_irq;
  logic        a_phase;

  assign clr    = hw_reset_in;
  assign pd     = digital_powerdown_input_in | ctrl.soft_pd;
  assign single = (ctrl.mode == updc_pkg::UPDC_SINGLE);
  assign prof   = {profile_select_high_in, profile_select_low_in};
  assign wtick  = (div_cnt == `UPDC_DIV_ONE) && !single && !pd;
  // words are taken on the rising word clock edge the source times against
  assign word_take = wtick && !wclk;
  assign upd_rise  = single && word_pin_in && !upd_d && !pd;
  assign prof_chg  = (prof != prof_d);
  assign a_phase   = hsel_in && htrans_in[1] && hready_in;

  always_comb
  begin
    ev = `UPDC_EV_ZERO;
    ev[`UPDC_EV_OVF]  = interp_overflow_in;
    // no lock event in the first cycle after reset, lock_d is not yet valid
    ev[`UPDC_EV_LOCK] = lock_arm && (pll_locked_in != lock_d);
    ev[`UPDC_EV_UPD]  = upd_rise;
    ev[`UPDC_EV_PROF] = prof_chg;
  end

  // word clock divider and data assembler
  always_comb
  begin
    next_div_cnt = div_cnt;
    next_wclk    = wclk;
    next_i_hold  = i_hold;
    next_want_q  = want_q;
    next_iq      = iq;
    next_iq_vld  = 1'b0;
    if (single || pd)
    begin
      next_div_cnt = ctrl.div;
      next_wclk    = 1'b0;
    end
    else if (wtick)
    begin
      next_div_cnt = ctrl.div;
      next_wclk    = !wclk;
    end
    else
    begin
      next_div_cnt = div_cnt - `UPDC_DIV_ONE;
    end
    if (!transmit_gate_in)
    begin
      next_want_q = 1'b0;
      if (word_take)
      begin
        next_iq     = '0;
        next_iq_vld = 1'b1;
      end
    end
    else if (word_take)
    begin
      if (ctrl.mode == updc_pkg::UPDC_INTERP)
      begin
        next_iq.i_word = parallel_word_bus_in;
        next_iq.q_word = '0;
        next_iq_vld    = 1'b1;
      end
      else if (!want_q)
      begin
        next_i_hold = parallel_word_bus_in;
        next_want_q = 1'b1;
      end
      else
      begin
        // quad mode spends two word clocks per sample pair
        next_iq.i_word = i_hold;
        next_iq.q_word = parallel_word_bus_in;
        next_iq_vld    = 1'b1;
        next_want_q    = 1'b0;
      end
    end
  end

  // tuning word transfer
  always_comb
  begin
    next_upd_d    = word_pin_in;
    next_prof_d   = prof;
    next_lock_d   = pll_locked_in;
    next_lock_arm = 1'b1;
    next_ovf_q    = interp_overflow_in;
    next_acc_tw   = acc_tw;
    if (prof_chg)
      next_acc_tw = tw[prof];
    else if (upd_rise)
      next_acc_tw = tw[prof];
  end

  // bus slave: zero wait states, always OKAY
  always_comb
  begin
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    for (int k = 0; k < 4; k++)
      next_tw[k] = tw[k];
    next_wr_pend  = a_phase && hwrite_in;
    next_rd_pend  = a_phase && !hwrite_in;
    next_dp_addr  = a_phase ? haddr_in : dp_addr;
    next_rdata    = rdata;
    rd_irq        = rd_pend && (dp_addr == `UPDC_A_IRQ);
    if (wr_pend)
    begin
      case (dp_addr)
        `UPDC_A_CTRL: next_ctrl     = hwdata_in[11:0];
        `UPDC_A_MASK: next_irq_mask = hwdata_in[3:0];
        `UPDC_A_TW0:  next_tw[0]    = hwdata_in;
        `UPDC_A_TW1:  next_tw[1]    = hwdata_in;
        `UPDC_A_TW2:  next_tw[2]    = hwdata_in;
        `UPDC_A_TW3:  next_tw[3]    = hwdata_in;
        default:      next_ctrl     = ctrl;
      endcase
    end
    if (a_phase && !hwrite_in)
    begin
      case (haddr_in)
        `UPDC_A_CTRL: next_rdata = {20'h0_0000, ctrl};
        `UPDC_A_STAT: next_rdata = {27'h000_0000, want_q, pd,
                                    differential_clock_select_in,
                                    pll_locked_in, single};
        `UPDC_A_IRQ:  next_rdata = {28'h000_0000, irq_st};
        `UPDC_A_MASK: next_rdata = {28'h000_0000, irq_mask};
        `UPDC_A_TW0:  next_rdata = tw[0];
        `UPDC_A_TW1:  next_rdata = tw[1];
        `UPDC_A_TW2:  next_rdata = tw[2];
        `UPDC_A_TW3:  next_rdata = tw[3];
        `UPDC_A_ACC:  next_rdata = acc_tw;
        `UPDC_A_IQ:   next_rdata = {4'h0, iq};
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
    // new events win over the read clear, and only the bits that the read
    // returned are cleared, so an event in the address phase is not lost
    next_irq_st = (irq_st & ~(rd_irq ? rdata[3:0] : `UPDC_EV_ZERO)) | ev;
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl     <= `UPDC_CTRL_RST;
      for (int k = 0; k < 4; k++)
        tw[k]  <= 32'h0000_0000;
      acc_tw   <= 32'h0000_0000;
      irq_st   <= `UPDC_EV_ZERO;
      irq_mask <= `UPDC_EV_ZERO;
      iq       <= '0;
      iq_vld   <= 1'b0;
      i_hold   <= 14'h0000;
      want_q   <= 1'b0;
      div_cnt  <= `UPDC_DIV_RST;
      wclk     <= 1'b0;
      upd_d    <= 1'b0;
      prof_d   <= 2'h0;
      lock_d   <= 1'b0;
      lock_arm <= 1'b0;
      ovf_q    <= 1'b0;
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      dp_addr  <= 32'h0000_0000;
      rdata    <= 32'h0000_0000;
    end
    else if (clr)
    begin
      // hardware reset pin acts synchronously on all block state
      ctrl     <= `UPDC_CTRL_RST;
      for (int k = 0; k < 4; k++)
        tw[k]  <= 32'h0000_0000;
      acc_tw   <= 32'h0000_0000;
      irq_st   <= `UPDC_EV_ZERO;
      irq_mask <= `UPDC_EV_ZERO;
      iq       <= '0;
      iq_vld   <= 1'b0;
      i_hold   <= 14'h0000;
      want_q   <= 1'b0;
      div_cnt  <= `UPDC_DIV_RST;
      wclk     <= 1'b0;
      upd_d    <= 1'b0;
      prof_d   <= 2'h0;
      lock_d   <= 1'b0;
      lock_arm <= 1'b0;
      ovf_q    <= 1'b0;
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      dp_addr  <= 32'h0000_0000;
      rdata    <= 32'h0000_0000;
    end
    else
    begin
      ctrl     <= next_ctrl;
      for (int k = 0; k < 4; k++)
        tw[k]  <= next_tw[k];
      acc_tw   <= next_acc_tw;
      irq_st   <= next_irq_st;
      irq_mask <= next_irq_mask;
      iq       <= next_iq;
      iq_vld   <= next_iq_vld;
      i_hold   <= next_i_hold;
      want_q   <= next_want_q;
      div_cnt  <= next_div_cnt;
      wclk     <= next_wclk;
      upd_d    <= next_upd_d;
      prof_d   <= next_prof_d;
      lock_d   <= next_lock_d;
      lock_arm <= next_lock_arm;
      ovf_q    <= next_ovf_q;
      wr_pend  <= next_wr_pend;
      rd_pend  <= next_rd_pend;
      dp_addr  <= next_dp_addr;
      rdata    <= next_rdata;
    end
  end

  assign word_pin_out      = wclk;
  assign word_pin_oe_n_out = single;
  assign pll_lock_out      = pll_locked_in;
  assign interpolator_overflow_flag_out = ovf_q;
  assign differential_ref_out = differential_clock_select_in;
  assign pll_run_out       = !pd || ctrl.keep_pll;
  assign digital_run_out   = !pd;
  assign iq_out            = iq;
  assign iq_valid_out      = iq_vld;
  assign accum_tw_out      = acc_tw;
  assign irq_out           = |(irq_st & irq_mask);
  assign hrdata_out        = rdata;
  assign hreadyout_out     = 1'b1;
  assign hresp_out         = 1'b0;

  chk_gate_zero: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (word_take && !transmit_gate_in && !clr) |=> (iq_vld && iq == '0))
    else $error("gated word not zero");
  chk_pair_order: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (word_take && transmit_gate_in && !want_q && !clr &&
     ctrl.mode == updc_pkg::UPDC_QUAD) |=> (want_q && !iq_vld))
    else $error("first word not held as I");
  chk_pin_dir: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    word_pin_oe_n_out == (ctrl.mode == updc_pkg::UPDC_SINGLE))
    else $error("shared pin direction wrong");
  chk_wclk_toggle: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (wtick && !clr) |=> (word_pin_out != $past(word_pin_out)))
    else $error("word clock did not toggle");
  chk_upd_load: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (upd_rise && !prof_chg && !clr) |=> acc_tw == $past(tw[prof]))
    else $error("update strobe did not load");
  chk_prof_load: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (prof_chg && !clr) |=> acc_tw == $past(tw[prof]))
    else $error("profile change did not load");
  chk_pd_stop: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    pd |=> (!iq_vld && !wclk))
    else $error("data moved in power-down");
  chk_pll_keep: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (pd && !ctrl.keep_pll) |-> !pll_run_out)
    else $error("pll run wrong");
  chk_hw_reset: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    clr |=> (acc_tw == 32'h0000_0000 && !iq_vld && !wclk))
    else $error("hardware reset left state");
  chk_interp_i: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (word_take && transmit_gate_in && !clr &&
     ctrl.mode == updc_pkg::UPDC_INTERP) |=>
     (iq_vld && iq.i_word == $past(parallel_word_bus_in)))
    else $error("interp word not on I");
  chk_ovf_follow: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (interp_overflow_in && !clr) |=> interpolator_overflow_flag_out)
    else $error("overflow not shown");
  chk_ovf_event: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (interp_overflow_in && !clr) |=> irq_st[`UPDC_EV_OVF])
    else $error("overflow event lost");
endmodule

// ===== updc_src.sv
// baseband word source model facing the data port
`timescale 1ns/100ps
module updc_src (
  input  wire logic   clk_in,
  input  wire logic   pin_in,
  input  wire logic   drive_in,
  input  wire logic   gate_req_in,
  input  wire logic   strobe_req_in,
  output logic [13:0] data_out = 14'h0000,
  output logic        gate_out = 1'b0,
  output logic        strobe_out = 1'b0
);
  logic pin_q = 1'b0;
  always @(posedge clk_in)
  begin
    pin_q <= pin_in;
    strobe_out <= strobe_req_in & ~drive_in;
    // a released bus never holds a stale word
    if (!drive_in)
      data_out <= ~data_out;
    else if (pin_in && !pin_q)
    begin
      data_out <= 14'($urandom);
      gate_out <= gate_req_in;
    end
  end
endmodule

// ===== tb_top.sv
// self-checking bench for the upconverter data port control block
`timescale 1ns/100ps
`include "updc_cfg.svh"
module tb_top;
  logic        mclk_in = 1'b0, rstn_in = 1'b0, hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0000_0000, hwdata_in = 32'h0000_0000;
  logic [1:0]  htrans_in = 2'h0;
  logic        hwrite_in = 1'b0, hready_in, hreadyout_out, hresp_out;
  logic [2:0]  hsize_in = 3'h2;
  logic [31:0] hrdata_out, accum_tw_out;
  logic [13:0] parallel_word_bus_in, i_hold;
  logic        transmit_gate_in, word_pin_in, word_pin_out;
  logic        word_pin_oe_n_out, pin, src_strobe, strobe_req = 1'b0;
  logic        profile_select_high_in = 1'b0, profile_select_low_in = 1'b0;
  logic        digital_powerdown_input_in = 1'b0, hw_reset_in = 1'b0;
  logic        differential_clock_select_in = 1'b0, pll_locked_in = 1'b1;
  logic        interp_overflow_in = 1'b0, pll_lock_out, differential_ref_out;
  logic        interpolator_overflow_flag_out, pll_run_out, digital_run_out;
  logic        iq_valid_out, irq_out, gate_req = 1'b0;
  logic        want_q = 1'b0, pin_q = 1'b0;
  logic [7:0]  div_set;
  updc_pkg::updc_iq_t   iq_out;
  updc_pkg::updc_iq_t   exp_q[$];
  updc_pkg::updc_mode_t mode_set = updc_pkg::UPDC_QUAD;
  int          fail_count = 0, tests_run = 0, gap = 0, cyc = 0;

  assign hready_in = hreadyout_out;
  assign pin = word_pin_oe_n_out ? src_strobe : word_pin_out;
  assign word_pin_in = pin;

  updc_top i_dut (.mclk_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out,
    .hreadyout_out, .hresp_out, .parallel_word_bus_in, .transmit_gate_in,
    .word_pin_in, .word_pin_out, .word_pin_oe_n_out,
    .profile_select_high_in, .profile_select_low_in,
    .digital_powerdown_input_in, .hw_reset_in, .differential_clock_select_in,
    .pll_locked_in, .interp_overflow_in, .pll_lock_out,
    .interpolator_overflow_flag_out, .differential_ref_out, .pll_run_out,
    .digital_run_out, .iq_out, .iq_valid_out, .accum_tw_out, .irq_out);

  updc_src i_src (.clk_in(mclk_in), .pin_in(pin),
    .drive_in(!word_pin_oe_n_out), .gate_req_in(gate_req),
    .strobe_req_in(strobe_req), .data_out(parallel_word_bus_in),
    .gate_out(transmit_gate_in), .strobe_out(src_strobe));

  always #5 mclk_in = ~mclk_in;

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, far above the under two thousand cycles the run needs
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] rd);
    @(posedge mclk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    rd = hrdata_out;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [31:0] a, m, e, input string s);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    check((x & m) === e && hresp_out === 1'b0, s);
  endtask

  function automatic logic [31:0] ctrl(logic [1:0] m, logic sp, logic kp);
    return {20'h00000, div_set, kp, sp, m};
  endfunction

  function automatic void take(logic g, logic [13:0] w);
    if (!g)
    begin
      want_q = 1'b0;
      exp_q.push_back(28'h0000000);
    end
    else if (mode_set == updc_pkg::UPDC_INTERP)
      exp_q.push_back({w, 14'h0000});
    else if (!want_q)
    begin
      i_hold = w;
      want_q = 1'b1;
    end
    else
    begin
      exp_q.push_back({i_hold, w});
      want_q = 1'b0;
    end
  endfunction

  // sampled mid-cycle so the word taken at the rising edge still stands
  always @(negedge mclk_in)
  begin
    if (pin && !pin_q && !word_pin_oe_n_out && digital_run_out && rstn_in)
    begin
      if (gate_req && gap > 0 && mode_set == updc_pkg::UPDC_QUAD)
        check(gap == 2 * div_set, "word clock period");
      gap = 0;
      take(transmit_gate_in, parallel_word_bus_in);
    end
    if (iq_valid_out === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected pair");
      else
        check(iq_out === exp_q.pop_front(), "pair value");
    end
    pin_q = pin;
    gap++;
  end

  task automatic stream(input updc_pkg::updc_mode_t m, input int n);
    wr(`UPDC_A_CTRL, ctrl(m, 1'b0, 1'b0));
    mode_set = m;
    repeat (4) @(posedge pin);
    exp_q.delete();
    check(word_pin_oe_n_out === 1'b0, "pin not driven");
    gate_req <= 1'b1;
    repeat (n) @(posedge pin);
    gate_req <= 1'b0;
    repeat (4) @(posedge pin);
    check(exp_q.size() == 0, "missing pair");
  endtask

  task automatic tone();
    logic [31:0] f [4];
    logic [1:0]  p;
    wr(`UPDC_A_CTRL, ctrl(updc_pkg::UPDC_SINGLE, 1'b0, 1'b0));
    mode_set = updc_pkg::UPDC_SINGLE;
    #1;
    check(word_pin_oe_n_out === 1'b1, "pin not released");
    for (int k = 0; k < 4; k++)
    begin
      f[k] = $urandom;
      wr(`UPDC_A_TW0 + 4 * k, f[k]);
    end
    for (int k = 1; k < 5; k++)
    begin
      p = 2'(k);
      profile_select_high_in <= p[1];
      profile_select_low_in <= p[0];
      repeat (3) @(posedge mclk_in);
      check(accum_tw_out === f[p], "profile load");
    end
    wr(`UPDC_A_TW0, ~f[0]);
    check(accum_tw_out === f[0], "load without strobe");
    strobe_req <= 1'b1;
    repeat (3) @(posedge mclk_in);
    strobe_req <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check(accum_tw_out === ~f[0], "strobe load");
    rdchk(`UPDC_A_IRQ, 32'h0000_000C, 32'h0000_000C, "tone events");
  endtask

  task automatic pins();
    logic [1:0]  v;
    logic        a;
    logic [31:0] x;
    for (int k = 0; k < 6; k++)
    begin
      v = 2'($urandom);
      @(posedge mclk_in);
      pll_locked_in <= v[0];
      differential_clock_select_in <= v[1];
      #1;
      check(pll_lock_out === v[0], "lock copy");
      check(differential_ref_out === v[1], "clock select");
    end
    repeat (3) @(posedge mclk_in);
    ahb(1'b0, `UPDC_A_IRQ, 32'h0000_0000, x);
    check(interpolator_overflow_flag_out === 1'b0, "flag idle");
    interp_overflow_in <= 1'b1;
    @(posedge mclk_in);
    interp_overflow_in <= 1'b0;
    #1;
    check(interpolator_overflow_flag_out === 1'b1, "flag pulse");
    wr(`UPDC_A_MASK, 32'h0000_0000);
    #1;
    a = irq_out;
    wr(`UPDC_A_MASK, 32'h0000_000F);
    #1;
    check((a ^ irq_out) === 1'b1, "mask");
    rdchk(`UPDC_A_IRQ, 32'h0000_000F, 32'h0000_0001, "overflow");
    #1;
    check(irq_out === 1'b0, "irq cleared");
  endtask

  task automatic pdown();
    logic [2:0] k;
    for (int j = 0; j < 8; j++)
    begin
      k = 3'(j);
      digital_powerdown_input_in <= k[0];
      wr(`UPDC_A_CTRL, ctrl(updc_pkg::UPDC_QUAD, k[1], k[2]));
      #1;
      check(digital_run_out === !(k[0] | k[1]), "digital run");
      check(pll_run_out === (!(k[0] | k[1]) | k[2]), "pll run");
    end
    digital_powerdown_input_in <= 1'b0;
  endtask

  initial
  begin
    void'($urandom(32'h0000_05DF));
    div_set = 8'($urandom_range(5, 2));
    repeat (10) @(posedge mclk_in);
    rstn_in <= 1'b1;
    pins();
    for (int k = 0; k < 6; k++)
      stream(k[0] ? updc_pkg::UPDC_INTERP : updc_pkg::UPDC_QUAD,
             $urandom_range(12, 3));
    tone();
    stream(updc_pkg::UPDC_QUAD, 7);
    pdown();
    @(posedge mclk_in);
    hw_reset_in <= 1'b1;
    @(posedge mclk_in);
    hw_reset_in <= 1'b0;
    rdchk(`UPDC_A_CTRL, 32'hFFFF_FFFF, `UPDC_CTRL_RST, "ctrl reset");
    check(accum_tw_out === 32'h0000_0000, "word reset");
    stream(updc_pkg::UPDC_QUAD, 8);
    tally_and_finish();
  end
endmodule
